//--- pic_pkg.sv
// Package for the priority interrupt controller: register map, fields, resets, codes.
// Assumes a 40 MHz single clock and byte addresses on a 32-bit AXI4-Lite bus.
package pic_pkg;
  localparam int NIRQ = 16;
  localparam int NINT = 8;
  localparam int NSRC = 24;
  localparam int NEXC = 5;
  localparam int NIPR = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_ICTL     = 8'h00;
  localparam logic [7:0] OFS_CPUPC    = 8'h04;
  localparam logic [7:0] OFS_LINE_EN  = 8'h08;
  localparam logic [7:0] OFS_SENSE_HI = 8'h0C;
  localparam logic [7:0] OFS_SENSE_LO = 8'h10;
  localparam logic [7:0] OFS_STAT     = 8'h14;
  localparam logic [7:0] OFS_ROUTE    = 8'h18;
  localparam logic [7:0] OFS_PEND     = 8'h1C;
  localparam logic [2:0] OFS_IPR_BLK  = 3'h1;
  // Field positions
  localparam int ICTL_MODE_LSB = 4;
  localparam int ICTL_NMI_EDGE_SELECT    = 3;
  localparam int CPUPC_ENABLE  = 7;
  localparam int CPUPC_DTC_LSB = 4;
  localparam int CPUPC_AUTO    = 3;
  localparam int CPUPC_LVL_LSB = 0;
  localparam int ROUTE_CPU_TOO = 24;
  // Reset values and writable masks
  localparam logic [7:0]  ICTL_RST    = 8'h00;
  localparam logic [7:0]  ICTL_WMASK  = 8'h38;
  localparam logic [7:0]  CPUPC_RST   = 8'h00;
  localparam logic [15:0] IPR_RST     = 16'h7777;
  localparam logic [15:0] IPR_WMASK   = 16'h7777;
  localparam logic [15:0] LINE_EN_RST = 16'h0000;
  localparam logic [31:0] SENSE_RST   = 32'h00000000;
  localparam logic [24:0] ROUTE_RST   = 25'h0000000;
  // Control modes and sense codes
  localparam logic [1:0] MODE0    = 2'h0;
  localparam logic [1:0] MODE2    = 2'h2;
  localparam logic [1:0] SNS_LOW  = 2'h0;
  localparam logic [1:0] SNS_FALL = 2'h1;
  localparam logic [1:0] SNS_RISE = 2'h2;
  // Vectors and levels
  localparam logic [7:0] VEC_NMI      = 8'h07;
  localparam logic [7:0] VEC_EXC_BASE = 8'h08;
  localparam logic [7:0] VEC_SRC_BASE = 8'h40;
  localparam logic [3:0] LVL_TOP      = 4'h8;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : pic_pkg

//--- pic_reg_if.sv
// Internal register access carrier between the bus slave and the register file.
// Assumes one write and one read strobe per cycle at most.
`timescale 1ns/1ps
`default_nettype none
interface pic_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : pic_reg_if
`default_nettype wire

//--- pic_sense.sv
// Edge or level detector for one interrupt pin.
// Assumes the pin is already synchronous to clock; idle level is high.
`timescale 1ns/1ps
`default_nettype none
module pic_sense (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  // Detection
  output logic            det
);
  import pic_pkg::*;
  logic prev_q;
  wire  fell = prev_q & ~pin;
  wire  rose = ~prev_q & pin;

  // Previous sample resets high so an idle-high pin gives no false edge
  always_ff @(posedge clock) begin
    if (rst) prev_q <= 1'b1;
    else     prev_q <= pin;
  end

  assign det = (mode == SNS_LOW) ? ~pin : ((fell & mode[0]) | (rose & mode[1]));
endmodule : pic_sense
`default_nettype wire

//--- pic_axil.sv
// AXI4-Lite slave front end; turns bus transfers into register strobes.
// Assumes one outstanding write and one outstanding read.
`timescale 1ns/1ps
`default_nettype none
module pic_axil (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // Write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // Read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Register side
  pic_reg_if.bus           rif
);
  import pic_pkg::*;
  logic        aw_have_q, w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire do_rd = s_axi_arvalid & s_axi_arready;
  assign rif.wr_en   = do_wr;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_addr = s_axi_araddr;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) aw_have_q <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) w_have_q <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rif.rd_ok ? rif.rd_data : 32'h00000000;
      s_axi_rresp  <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule : pic_axil
`default_nettype wire

//--- pic_ctrl.sv
// Priority interrupt controller top: registers, line detection, arbitration, vectors.
// Assumes pins synchronous to clock and a CPU that pulses ack while a request shows.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//Contract
// - mode 00 gates maskables by one mask bit
// - mode 10 uses three-bit mask and levels
// - NMI edge falling at 0, rising at 1
// - control reserved bits read zero, ignore writes
// - NMI highest, accepted regardless of masking
// - five level-8 requests always accepted
// - each line falling, rising, both or level
// - every source gets its own vector
// - enable bit 0 makes CPU lowest
// - three-bit transfer controller priority level
// - auto mode copies CPU mask into level
// - auto mode makes CPU level read-only
// - enabled, CPU level ranks against transfers
// - CPU handling may preempt pending transfers
// - four 3-bit fields, reset 111, gaps zero
// - levels 0 to 7 for non-NMI sources
// - one enable bit per external line
// - requests may start transfers, CPU too
// - disabled line's request is blocked
// - sense codes low, fall, rise, both
module pic_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite register bus
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Interrupt sources
  input  wire logic        nmi_pin,
  input  wire logic [15:0] maskable_ext_lines,
  input  wire logic [7:0]  int_req,
  input  wire logic [4:0]  exc_req,
  // CPU side
  input  wire logic        ccr_mask,
  input  wire logic [2:0]  three_bit_mask,
  output logic             cpu_irq_req,
  output logic [7:0]       cpu_irq_vec,
  output logic [3:0]       cpu_irq_level,
  input  wire logic        cpu_irq_ack,
  // Transfer engines
  output logic [23:0]      xfer_req,
  input  wire logic [23:0] xfer_done,
  input  wire logic [2:0]  dmac_prio,
  output logic             xfer_hold_dtc,
  output logic             xfer_hold_dmac
);
  import pic_pkg::*;

  pic_reg_if rif ();

  pic_axil u_axil (
    .clock         (clock),
    .rst           (rst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .rif           (rif)
  );

  // Registers
  logic [7:0]  interrupt_control_q;
  logic [7:0]  cpu_priority_control_q;
  logic [15:0] source_priority_levels_q [NIPR];
  logic [15:0] external_line_enable_q;
  logic [31:0] sense_select_q;
  logic [15:0] line_status_flags_q;
  logic [24:0] route_q;
  logic        nmi_flag_q;
  logic        sel_nmi_q;
  logic        sel_src_q;
  logic [4:0]  sel_idx_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [31:0] m);
    merge = (old & ~m) | (dat & m);
  endfunction : merge

  // Write decode
  wire [31:0] wmask    = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}}, {8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
  wire        wr_al    = rif.wr_en && (rif.wr_addr[1:0] == 2'h0);
  wire        wr_ictl  = wr_al && (rif.wr_addr == OFS_ICTL);
  wire        wr_cpupc = wr_al && (rif.wr_addr == OFS_CPUPC);
  wire        wr_len   = wr_al && (rif.wr_addr == OFS_LINE_EN);
  wire        wr_shi   = wr_al && (rif.wr_addr == OFS_SENSE_HI);
  wire        wr_slo   = wr_al && (rif.wr_addr == OFS_SENSE_LO);
  wire        wr_stat  = wr_al && (rif.wr_addr == OFS_STAT);
  wire        wr_route = wr_al && (rif.wr_addr == OFS_ROUTE);
  wire        wr_ipr_blk = wr_al && (rif.wr_addr[7:5] == OFS_IPR_BLK) && (32'(rif.wr_addr[4:2]) < NIPR);
  wire [2:0]  wr_ipr_idx = rif.wr_addr[4:2];
  assign rif.wr_ok = wr_ictl | wr_cpupc | wr_len | wr_shi | wr_slo | wr_stat | wr_route | wr_ipr_blk
                   | (wr_al && rif.wr_addr == OFS_PEND);

  // Control register; prohibited mode codes leave the mode unchanged
  wire [7:0] ictl_m   = 8'(merge({24'h0, interrupt_control_q}, rif.wr_data, wmask)) & ICTL_WMASK;
  wire [1:0] mode_new = ictl_m[ICTL_MODE_LSB +: 2];
  wire       mode_ok  = (mode_new == MODE0) || (mode_new == MODE2);
  wire [1:0] mode     = interrupt_control_q[ICTL_MODE_LSB +: 2];
  wire       mode2    = (mode == MODE2);
  wire       nmi_edge_select    = interrupt_control_q[ICTL_NMI_EDGE_SELECT];

  always_ff @(posedge clock) begin
    if (rst) interrupt_control_q <= ICTL_RST;
    else if (wr_ictl) interrupt_control_q <= mode_ok ? ictl_m
        : {ictl_m[7:6], mode, ictl_m[3:0]};
  end

  // CPU priority control
  wire       cpue     = cpu_priority_control_q[CPUPC_ENABLE];
  wire       auto_set = cpu_priority_control_q[CPUPC_AUTO];
  wire [2:0] dtc_lvl  = cpu_priority_control_q[CPUPC_DTC_LSB +: 3];
  wire [2:0] cpu_lvl  = cpu_priority_control_q[CPUPC_LVL_LSB +: 3];
  wire [7:0] cpupc_m  = 8'(merge({24'h0, cpu_priority_control_q}, rif.wr_data, wmask));
  wire [2:0] cur_mask = mode2 ? three_bit_mask : {3{ccr_mask}};
  wire [2:0] lvl_next = auto_set ? cur_mask : (wr_cpupc ? cpupc_m[2:0] : cpu_lvl);

  always_ff @(posedge clock) begin
    if (rst) cpu_priority_control_q <= CPUPC_RST;
    else     cpu_priority_control_q <= {(wr_cpupc ? cpupc_m[7:3] : cpu_priority_control_q[7:3]), lvl_next};
  end

  // Priority, enable, sense, routing registers
  always_ff @(posedge clock) begin
    for (int r = 0; r < NIPR; r++) begin
      if (rst) source_priority_levels_q[r] <= IPR_RST;
      else if (wr_ipr_blk && (32'(wr_ipr_idx) == r))
        source_priority_levels_q[r] <= 16'(merge({16'h0, source_priority_levels_q[r]}, rif.wr_data, wmask))
                                       & IPR_WMASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      external_line_enable_q <= LINE_EN_RST;
      sense_select_q         <= SENSE_RST;
      route_q                <= ROUTE_RST;
    end else begin
      if (wr_len) external_line_enable_q <= 16'(merge({16'h0, external_line_enable_q}, rif.wr_data, wmask));
      if (wr_shi) sense_select_q[31:16] <= 16'(merge({16'h0, sense_select_q[31:16]}, rif.wr_data, wmask));
      if (wr_slo) sense_select_q[15:0] <= 16'(merge({16'h0, sense_select_q[15:0]}, rif.wr_data, wmask));
      if (wr_route) route_q <= 25'(merge({7'h0, route_q}, rif.wr_data, wmask));
    end
  end

  // Line detection
  logic [15:0] irq_det;
  logic        nmi_det;
  for (genvar g = 0; g < NIRQ; g++) begin : g_sense
    pic_sense u_sense (
      .clock (clock),
      .rst   (rst),
      .pin   (maskable_ext_lines[g]),
      .mode  (sense_select_q[2*g +: 2]),
      .det   (irq_det[g])
    );
  end
  pic_sense u_nmi (
    .clock (clock),
    .rst   (rst),
    .pin   (nmi_pin),
    .mode  (nmi_edge_select ? SNS_RISE : SNS_FALL),
    .det   (nmi_det)
  );

  // Flags: a detection in the clearing cycle wins over the clear
  wire        ack_ok   = cpu_irq_ack && cpu_irq_req;
  wire        ack_nmi  = ack_ok && sel_nmi_q;
  wire        ack_line = ack_ok && sel_src_q && !sel_idx_q[4];
  wire        cpu_too  = route_q[ROUTE_CPU_TOO];
  wire [15:0] sw_clr   = {16{wr_stat}} & wmask[15:0] & ~rif.wr_data[15:0];
  wire [15:0] ack_clr  = ack_line ? (16'h0001 << sel_idx_q[3:0]) : 16'h0000;
  wire [15:0] done_clr = xfer_done[15:0] & route_q[15:0] & {16{~cpu_too}};

  always_ff @(posedge clock) begin
    if (rst) begin
      line_status_flags_q <= 16'h0000;
      nmi_flag_q          <= 1'b0;
    end else begin
      line_status_flags_q <= irq_det | (line_status_flags_q & ~(sw_clr | ack_clr | done_clr));
      nmi_flag_q          <= nmi_det | (nmi_flag_q & ~ack_nmi);
    end
  end

  // Source pending and routing
  wire [23:0] src_pend = {int_req, line_status_flags_q & external_line_enable_q};
  wire [23:0] to_cpu   = src_pend & (~route_q[23:0] | {24{cpu_too}});
  wire [23:0] to_xfer  = src_pend & route_q[23:0];

  // Arbitration among maskable sources
  logic       best_ok;
  logic [2:0] best_lvl;
  logic [4:0] best_idx;
  logic [2:0] exc_idx;
  always_comb begin
    best_ok  = 1'b0;
    best_lvl = 3'h0;
    best_idx = 5'h00;
    for (int i = 0; i < NSRC; i++) begin
      logic [2:0] lv;
      lv = source_priority_levels_q[i / 4][4 * (i % 4) +: 3];
      if (to_cpu[i] && (mode2 ? (lv > three_bit_mask) : !ccr_mask)
          && (!best_ok || (mode2 && lv > best_lvl))) begin
        best_ok  = 1'b1;
        best_lvl = mode2 ? lv : 3'h0;
        best_idx = 5'(i);
      end
    end
  end

  always_comb begin
    exc_idx = 3'h0;
    for (int e = NEXC - 1; e >= 0; e--) begin
      if (exc_req[e]) exc_idx = 3'(e);
    end
  end

  // Presented request, NMI first, then level-8 requests
  wire       any_req  = nmi_flag_q | (|exc_req) | best_ok;
  wire [7:0] vec_next = nmi_flag_q ? VEC_NMI
                      : (|exc_req) ? (VEC_EXC_BASE + {5'h00, exc_idx})
                      : (VEC_SRC_BASE + {3'h0, best_idx});
  wire [3:0] lvl_out  = (nmi_flag_q || (|exc_req)) ? LVL_TOP : {1'b0, best_lvl};

  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_irq_req   <= 1'b0;
      cpu_irq_vec   <= 8'h00;
      cpu_irq_level <= 4'h0;
      sel_nmi_q     <= 1'b0;
      sel_src_q     <= 1'b0;
      sel_idx_q     <= 5'h00;
    end else begin
      cpu_irq_req   <= any_req && !ack_ok;
      cpu_irq_vec   <= vec_next;
      cpu_irq_level <= lvl_out;
      sel_nmi_q     <= nmi_flag_q;
      sel_src_q     <= !nmi_flag_q && !(|exc_req) && best_ok;
      sel_idx_q     <= best_idx;
    end
  end

  // Transfer activation and CPU-versus-transfer holds; equal levels let the transfer run
  always_ff @(posedge clock) begin
    if (rst) begin
      xfer_req       <= 24'h000000;
      xfer_hold_dtc  <= 1'b0;
      xfer_hold_dmac <= 1'b0;
    end else begin
      xfer_req       <= to_xfer & ~xfer_done;
      xfer_hold_dtc  <= cpue && (cpu_lvl > dtc_lvl);
      xfer_hold_dmac <= cpue && (cpu_lvl > dmac_prio);
    end
  end

  // Read decode
  wire [2:0]  rd_ipr_idx = rif.rd_addr[4:2];
  wire        rd_al      = rif.rd_addr[1:0] == 2'h0;
  wire        rd_ipr     = rd_al && (rif.rd_addr[7:5] == OFS_IPR_BLK) && (32'(rd_ipr_idx) < NIPR);
  wire [15:0] ipr_rd     = rd_ipr ? source_priority_levels_q[rd_ipr_idx] : 16'h0000;
  wire [31:0] pend_rd    = {19'h0, cpu_irq_req, cpu_irq_level, cpu_irq_vec};
  assign rif.rd_data = !rd_al ? 32'h00000000
                     : (rif.rd_addr == OFS_ICTL)     ? {24'h0, interrupt_control_q}
                     : (rif.rd_addr == OFS_CPUPC)    ? {24'h0, cpu_priority_control_q}
                     : (rif.rd_addr == OFS_LINE_EN)  ? {16'h0, external_line_enable_q}
                     : (rif.rd_addr == OFS_SENSE_HI) ? {16'h0, sense_select_q[31:16]}
                     : (rif.rd_addr == OFS_SENSE_LO) ? {16'h0, sense_select_q[15:0]}
                     : (rif.rd_addr == OFS_STAT)     ? {15'h0, nmi_flag_q, line_status_flags_q}
                     : (rif.rd_addr == OFS_ROUTE)    ? {7'h0, route_q}
                     : (rif.rd_addr == OFS_PEND)     ? pend_rd
                     : {16'h0, ipr_rd};
  assign rif.rd_ok = rd_al && (rd_ipr || rif.rd_addr <= OFS_PEND);

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_nmi_fall;
    nmi_pin ##1 !nmi_pin;
  endsequence
  sequence s_nmi_rise;
    !nmi_pin ##1 nmi_pin;
  endsequence

  property p_nmi_edge;
    (s_nmi_fall ##0 !nmi_edge_select) or (s_nmi_rise ##0 nmi_edge_select) |=> nmi_flag_q ##1 sel_nmi_q;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge not caught");

  property p_nmi_top;
    nmi_flag_q && !ack_ok |=> cpu_irq_req && cpu_irq_vec == VEC_NMI && cpu_irq_level == LVL_TOP;
  endproperty
  a_nmi_top: assert property (p_nmi_top) else $error("nmi not presented first");

  property p_exc_always;
    !nmi_flag_q && (|exc_req) && !ack_ok |=> cpu_irq_req && cpu_irq_level == LVL_TOP;
  endproperty
  a_exc_always: assert property (p_exc_always) else $error("level-8 request not presented");

  property p_mode0_mask;
    $past(mode) == MODE0 && $past(ccr_mask) && cpu_irq_req |-> cpu_irq_level == LVL_TOP;
  endproperty
  a_mode0_mask: assert property (p_mode0_mask) else $error("maskable passed mask bit");

  property p_mode2_mask;
    $past(mode2) && cpu_irq_req && cpu_irq_level != LVL_TOP |-> cpu_irq_level[2:0] > $past(three_bit_mask);
  endproperty
  a_mode2_mask: assert property (p_mode2_mask) else $error("level not above mask");

  property p_line_gate;
    cpu_irq_req && sel_src_q && !sel_idx_q[4] |-> |($past(external_line_enable_q) & (16'h0001 << sel_idx_q[3:0]));
  endproperty
  a_line_gate: assert property (p_line_gate) else $error("disabled line passed");

  property p_ictl_rsv;
    interrupt_control_q[7:6] == 2'h0 && interrupt_control_q[2:0] == 3'h0 && mode[0] == 1'b0;
  endproperty
  a_ictl_rsv: assert property (p_ictl_rsv) else $error("control reserved bit set");

  property p_ipr_rsv;
    (source_priority_levels_q[0] & ~IPR_WMASK) == 16'h0000;
  endproperty
  a_ipr_rsv: assert property (p_ipr_rsv) else $error("priority gap bit set");

  property p_auto_copy;
    auto_set && !wr_cpupc |=> cpu_lvl == $past(cur_mask);
  endproperty
  a_auto_copy: assert property (p_auto_copy) else $error("cpu level not tracking mask");

  property p_cpu_low;
    !$past(cpue) |-> !xfer_hold_dtc && !xfer_hold_dmac;
  endproperty
  a_cpu_low: assert property (p_cpu_low) else $error("hold while cpu lowest");

  property p_cpu_rank;
    cpue && cpu_lvl > dtc_lvl |=> xfer_hold_dtc;
  endproperty
  a_cpu_rank: assert property (p_cpu_rank) else $error("cpu level not ranked");
endmodule : pic_ctrl
`default_nettype wire

//--- pic_cpu_model.sv
// Stand-in for the CPU core and transfer engines facing the controller.
// Assumes request and transfer lines are registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Requests from the controller
  input  wire logic        cpu_irq_req,
  input  wire logic [23:0] xfer_req,
  // Answers
  output logic             cpu_irq_ack,
  output logic [23:0]      xfer_done
);
  logic gap_q;
  // Gap cycle keeps acknowledge pulses at least three cycles apart
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_irq_ack <= 1'b0;
      gap_q       <= 1'b0;
      xfer_done   <= 24'h000000;
    end else begin
      cpu_irq_ack <= cpu_irq_req & ~cpu_irq_ack & ~gap_q;
      gap_q       <= cpu_irq_ack;
      xfer_done   <= xfer_req & ~xfer_done;
    end
  end
endmodule : pic_cpu_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench: register bus tasks and a scripted scenario list.
// Assumes the controller top and the partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pic_pkg::*;
  logic        clock = 0, rst = 1, awv = 0, awr, wv = 0, wrdy, bv, brd = 0, arv = 0, arr, rv, rrd = 0;
  logic        nmi = 1, condition_code_reg = 0, req, ack, hdtc, hdma;
  logic [7:0]  awa = 0, ara = 0, vec, ireq = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0]  bresp, rresp;
  logic [15:0] ext = 16'hFFFF;
  logic [4:0]  exc = 0;
  logic [2:0]  msk = 0, dpri = 0;
  logic [3:0]  lvl;
  logic [23:0] xreq, xdone;
  int          n_mismatch = 0, comparisons = 0;
  pic_ctrl dut_u (.clock(clock), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .nmi_pin(nmi),
    .maskable_ext_lines(ext), .int_req(ireq), .exc_req(exc), .ccr_mask(condition_code_reg), .three_bit_mask(msk),
    .cpu_irq_req(req), .cpu_irq_vec(vec), .cpu_irq_level(lvl), .cpu_irq_ack(ack), .xfer_req(xreq),
    .xfer_done(xdone), .dmac_prio(dpri), .xfer_hold_dtc(hdtc), .xfer_hold_dmac(hdma));
  pic_cpu_model cpu_u (.clock(clock), .rst(rst), .cpu_irq_req(req), .xfer_req(xreq), .cpu_irq_ack(ack),
    .xfer_done(xdone));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // A used-up wait bound ends the run
  task automatic lim(input int n);
    if (n >= 60) begin
      n_mismatch++;
      end_sim();
    end
  endtask : lim
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    brd <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge clock);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      if (bv) break;
    end
    brd <= 0;
    lim(n);
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clock);
    arv <= 1;
    ara <= a;
    rrd <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge clock);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rrd <= 0;
    lim(n);
    chk(rdat, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rc
  task automatic wirq(input logic [7:0] v, input logic [3:0] l);
    int n;
    for (n = 0; n < 60; n++) begin
      @(negedge clock);
      if (req === 1'b1) break;
    end
    lim(n);
    chk({20'h0, lvl, vec}, {20'h0, l, v});
    repeat (8) @(negedge clock);
  endtask : wirq
  task automatic quiet;
    repeat (8) @(negedge clock);
    chk({31'h0, req}, 32'h0);
  endtask : quiet
  initial begin
    repeat (16) @(posedge clock);
    rst <= 0;
    rc(OFS_ICTL, 32'h0);
    rc(OFS_CPUPC, 32'h0);
    rc(OFS_LINE_EN, 32'h0);
    rc(8'h20, 32'h7777);
    wr(8'h20, 32'hFFFF);
    rc(8'h20, 32'h7777);
    rc(8'h40, 32'h0, RESP_SLVERR);
    wr(OFS_ICTL, 32'hFF);
    rc(OFS_ICTL, 32'h08);
    @(posedge clock) condition_code_reg <= 1;
    @(posedge clock) nmi <= 0;
    quiet();
    @(posedge clock) nmi <= 1;
    wirq(VEC_NMI, LVL_TOP);
    wr(OFS_SENSE_LO, 32'h40);
    @(posedge clock) ext[3] <= 0;
    quiet();
    wr(OFS_LINE_EN, 32'h8);
    quiet();
    @(posedge clock) condition_code_reg <= 0;
    wirq(VEC_SRC_BASE + 8'h3, 4'h0);
    @(posedge clock) ext[3] <= 1;
    wr(OFS_ICTL, 32'h20);
    wr(8'h20, 32'h5777);
    @(posedge clock) msk <= 3'h5;
    @(posedge clock) ext[3] <= 0;
    quiet();
    @(posedge clock) msk <= 3'h4;
    wirq(VEC_SRC_BASE + 8'h3, 4'h5);
    @(posedge clock) exc <= 5'h01;
    wirq(VEC_EXC_BASE, LVL_TOP);
    @(posedge clock) exc <= 5'h00;
    @(posedge clock) dpri <= 3'h3;
    wr(OFS_CPUPC, 32'h88);
    rc(OFS_CPUPC, 32'h8C);
    wr(OFS_CPUPC, 32'h8B);
    rc(OFS_CPUPC, 32'h8C);
    chk({30'h0, hdtc, hdma}, 32'h3);
    wr(OFS_CPUPC, 32'hF8);
    repeat (2) @(negedge clock);
    chk({30'h0, hdtc, hdma}, 32'h1);
    wr(OFS_CPUPC, 32'h08);
    repeat (2) @(negedge clock);
    chk({30'h0, hdtc, hdma}, 32'h0);
    // Line 3 routed to the engines only; the done pulse clears its flag
    @(posedge clock) ext[3] <= 1;
    wr(OFS_ROUTE, 32'h8);
    @(posedge clock) ext[3] <= 0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({8'h0, xreq}, 32'h8);
    quiet();
    chk({8'h0, xreq}, 32'h0);
    rc(OFS_STAT, 32'h0);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
